// ---- fbt_bus_timing.sv ----
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
module fbt_bus_timing
  import fbt_pkg::*;
#(
  parameter int unsigned TICK_10MS = TICK_10MS_DEF
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // host
  input wire logic exchange_start_request_i,
  // link layer
  input wire logic tx_start_i,
  input wire logic [6:0] tx_addr_i,
  input wire logic rx_resp_i,
  input wire logic rotation_done_i,
  output logic tx_ready_o,
  output logic retry_o,
  output logic exchange_active_o,
  output logic outputs_clear_o,
  output logic gap_update_o,
  output logic bit_tick_o,
  output logic irq_o
);

  typedef enum logic [1:0] {
    FBT_IDLE = 2'b00,
    FBT_WAIT = 2'b01,
    FBT_TURN = 2'b10
  } fbt_state_t;

  fbt_rate_t rate_q;
  logic clr_en_q, wdog_en_q;
  fbt_cfg_t cfg_q;
  fbt_rate_dflt_t turn_q;
  logic [9:0] maxdly_q;
  logic [23:0] ttr_q;
  logic [6:0] gap_q;
  logic [15:0] wdog_q;
  logic [ST_W-1:0] status_q, mask_q, ev;
  logic [31:0] rdata_d;
  fbt_state_t state_q;
  logic [11:0] div_cnt_q;
  logic tick_q;
  logic [13:0] slot_cnt_q;
  logic [8:0] turn_cnt_q;
  logic [2:0] retry_cnt_q;
  logic [23:0] rot_cnt_q;
  logic [6:0] gap_cnt_q;
  logic [31:0] ms_cnt_q;
  logic [15:0] cyc_cnt_q;
  logic clr_q, req_seen_low_q;
  logic ev_slot_to, ev_fault, ev_early, ev_ttr, ev_wdog, ev_rej, ev_gap;
  logic wr_ctrl, addr_ok;

  function automatic logic [31:0] clampv(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : clampv

  assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;

  // configuration registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_q <= RATE_DEF;
      clr_en_q <= 1'b0;
      wdog_en_q <= 1'b0;
      cfg_q <= '{SLOT_DEF, MINDLY_DEF, HSA_DEF, RETRY_DEF};
      turn_q <= '{10'h096, 7'h00, 8'h01};
      ttr_q <= TTR_DEF;
      gap_q <= GAP_DEF;
      wdog_q <= WDOG_DEF;
      mask_q <= '0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_CTRL: begin
          if (reg_wdata_i[CTRL_RATE_LSB +: 4] <= 4'h9) begin
            rate_q <= fbt_rate_t'(reg_wdata_i[CTRL_RATE_LSB +: 4]);
            turn_q <= fbt_dflt(fbt_rate_t'(reg_wdata_i[3:0]));
          end
          clr_en_q <= reg_wdata_i[CTRL_CLR_EN];
          wdog_en_q <= reg_wdata_i[CTRL_WDOG_EN];
        end
        OFS_SLOT: cfg_q.slot <= 14'(clampv(32'(reg_wdata_i[13:0]),
          32'(SLOT_MIN), 32'(SLOT_MAX)));
        OFS_MINDLY: cfg_q.mindly <= 10'(clampv(32'(reg_wdata_i[9:0]),
          32'(MINDLY_MIN), 32'(MINDLY_MAX)));
        OFS_MAXDLY: turn_q.maxdly <= 10'(clampv(32'(reg_wdata_i[9:0]),
          32'(MAXDLY_MIN), 32'(MAXDLY_MAX)));
        OFS_QUIET: turn_q.quiet <= 7'(clampv(32'(reg_wdata_i[6:0]),
          32'h0, 32'(QUIET_MAX)));
        OFS_SETUP: turn_q.setup <= 8'(clampv(32'(reg_wdata_i[7:0]),
          32'(SETUP_MIN), 32'(SETUP_MAX)));
        OFS_TTR: ttr_q <= 24'(clampv(32'(reg_wdata_i[23:0]),
          32'(TTR_MIN), 32'(TTR_MAX)));
        OFS_GAP: gap_q <= 7'(clampv(32'(reg_wdata_i[6:0]),
          32'(GAP_MIN), 32'(GAP_MAX)));
        OFS_HSA: cfg_q.hsa <= 7'(clampv(32'(reg_wdata_i[6:0]),
          32'(HSA_MIN), 32'(HSA_MAX)));
        OFS_RETRY: cfg_q.retry <= 3'(clampv(32'(reg_wdata_i[2:0]),
          32'(RETRY_MIN), 32'(RETRY_MAX)));
        OFS_WDOG: wdog_q <= reg_wdata_i[15:0];
        OFS_MASK: mask_q <= reg_wdata_i[ST_W-1:0];
        default: ;
      endcase
    end
  end

  assign maxdly_q = turn_q.maxdly;

  // bit-time tick from the core clock
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (wr_ctrl || div_cnt_q + 12'h001 >= fbt_bit_div(rate_q)) begin
      div_cnt_q <= '0;
      tick_q <= !wr_ctrl;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  assign addr_ok = tx_addr_i <= ADDR_MAX && tx_addr_i <= cfg_q.hsa;

  // response supervision and turnaround
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= FBT_IDLE;
      slot_cnt_q <= '0;
      turn_cnt_q <= '0;
      retry_cnt_q <= '0;
    end else begin
      unique case (state_q)
        FBT_IDLE: begin
          if (tx_start_i && addr_ok && !clr_q) begin
            state_q <= FBT_WAIT;
            slot_cnt_q <= '0;
            retry_cnt_q <= '0;
          end
        end
        FBT_WAIT: begin
          if (rx_resp_i) begin
            state_q <= FBT_TURN;
            turn_cnt_q <= '0;
          end else if (tick_q && slot_cnt_q >= cfg_q.slot) begin
            slot_cnt_q <= '0;
            if (retry_cnt_q < cfg_q.retry) begin
              retry_cnt_q <= retry_cnt_q + 3'h1;
            end else begin
              state_q <= FBT_IDLE;
            end
          end else if (tick_q) begin
            slot_cnt_q <= slot_cnt_q + 14'h0001;
          end
        end
        FBT_TURN: begin
          if (tick_q) begin
            if (turn_cnt_q + 9'h001 >= 9'(turn_q.setup) + 9'(turn_q.quiet))
            begin
              state_q <= FBT_IDLE;
            end else begin
              turn_cnt_q <= turn_cnt_q + 9'h001;
            end
          end
        end
        default: state_q <= FBT_IDLE;
      endcase
    end
  end

  assign ev_slot_to = state_q == FBT_WAIT && !rx_resp_i && tick_q &&
                      slot_cnt_q >= cfg_q.slot;
  assign ev_fault = ev_slot_to && retry_cnt_q >= cfg_q.retry;
  assign ev_early = state_q == FBT_WAIT && rx_resp_i &&
                    slot_cnt_q < 14'(cfg_q.mindly);
  assign ev_rej = state_q == FBT_IDLE && tx_start_i && !addr_ok;

  // token rotation and gap update timing
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rot_cnt_q <= '0;
      gap_cnt_q <= '0;
    end else if (rotation_done_i) begin
      rot_cnt_q <= '0;
      gap_cnt_q <= gap_cnt_q + 7'h01 >= gap_q ? 7'h00 : gap_cnt_q + 7'h01;
    end else if (tick_q && rot_cnt_q != TTR_MAX) begin
      rot_cnt_q <= rot_cnt_q + 24'h000001;
    end
  end

  assign ev_ttr = tick_q && rot_cnt_q + 24'h000001 == ttr_q;
  assign ev_gap = rotation_done_i && gap_cnt_q + 7'h01 >= gap_q;

  // bus cycle length in 10 ms units against slave watchdog
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_cnt_q <= '0;
      cyc_cnt_q <= '0;
    end else if (rotation_done_i) begin
      ms_cnt_q <= '0;
      cyc_cnt_q <= '0;
    end else if (ms_cnt_q + 32'h1 >= TICK_10MS) begin
      ms_cnt_q <= '0;
      if (cyc_cnt_q != 16'hFFFF) cyc_cnt_q <= cyc_cnt_q + 16'h0001;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  assign ev_wdog = rotation_done_i && wdog_en_q &&
                   cyc_cnt_q > wdog_q;

  // clear-on-error latch and restart by request cycling
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_q <= 1'b0;
      req_seen_low_q <= 1'b0;
    end else if (ev_fault && clr_en_q) begin
      clr_q <= 1'b1;
      req_seen_low_q <= 1'b0;
    end else if (clr_q && !exchange_start_request_i) begin
      req_seen_low_q <= 1'b1;
    end else if (clr_q && req_seen_low_q) begin
      clr_q <= 1'b0;
    end
  end

  assign ev = {ev_gap, ev_rej, ev_wdog, ev_ttr, ev_early, ev_fault,
               ev_slot_to};

  // sticky status, write one clears, new event wins
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= '0;
    end else if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
      status_q <= (status_q & ~reg_wdata_i[ST_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_ready_o <= 1'b0;
      retry_o <= 1'b0;
      exchange_active_o <= 1'b0;
      outputs_clear_o <= 1'b0;
      gap_update_o <= 1'b0;
      bit_tick_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      tx_ready_o <= state_q == FBT_IDLE && !clr_q && exchange_start_request_i;
      retry_o <= ev_slot_to && !ev_fault;
      exchange_active_o <= exchange_start_request_i && !clr_q;
      outputs_clear_o <= clr_q;
      gap_update_o <= ev_gap;
      bit_tick_o <= tick_q;
      irq_o <= |(status_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (reg_addr_i)
      OFS_CTRL: rdata_d = {26'h0, wdog_en_q, clr_en_q, rate_q};
      OFS_SLOT: rdata_d = {18'h0, cfg_q.slot};
      OFS_MINDLY: rdata_d = {22'h0, cfg_q.mindly};
      OFS_MAXDLY: rdata_d = {22'h0, maxdly_q};
      OFS_QUIET: rdata_d = {25'h0, turn_q.quiet};
      OFS_SETUP: rdata_d = {24'h0, turn_q.setup};
      OFS_TTR: rdata_d = {8'h0, ttr_q};
      OFS_GAP: rdata_d = {25'h0, gap_q};
      OFS_HSA: rdata_d = {25'h0, cfg_q.hsa};
      OFS_RETRY: rdata_d = {29'h0, cfg_q.retry};
      OFS_WDOG: rdata_d = {16'h0, wdog_q};
      OFS_STATUS: rdata_d = {25'h0, status_q};
      OFS_MASK: rdata_d = {25'h0, mask_q};
      OFS_STATE: rdata_d = {13'h0, retry_cnt_q, clr_q, 13'h0, state_q};
      default: rdata_d = '0;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0;
    end
  end

endmodule : fbt_bus_timing
`default_nettype wire

// ---- fbt_pkg.sv ----
`default_nettype none
package fbt_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_10MS_DEF = CLK_HZ / 100;

  typedef enum logic [3:0] {
    FBT_R9K6 = 4'h0, FBT_R19K2 = 4'h1, FBT_R45K45 = 4'h2,
    FBT_R93K75 = 4'h3, FBT_R187K5 = 4'h4, FBT_R500K = 4'h5,
    FBT_R1M5 = 4'h6, FBT_R3M = 4'h7, FBT_R6M = 4'h8, FBT_R12M = 4'h9
  } fbt_rate_t;
  localparam fbt_rate_t RATE_DEF = FBT_R1M5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT = 8'h04;
  localparam logic [7:0] OFS_MINDLY = 8'h08;
  localparam logic [7:0] OFS_MAXDLY = 8'h0C;
  localparam logic [7:0] OFS_QUIET = 8'h10;
  localparam logic [7:0] OFS_SETUP = 8'h14;
  localparam logic [7:0] OFS_TTR = 8'h18;
  localparam logic [7:0] OFS_GAP = 8'h1C;
  localparam logic [7:0] OFS_HSA = 8'h20;
  localparam logic [7:0] OFS_RETRY = 8'h24;
  localparam logic [7:0] OFS_WDOG = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_MASK = 8'h30;
  localparam logic [7:0] OFS_STATE = 8'h34;

  // control field positions
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_CLR_EN = 4;
  localparam int CTRL_WDOG_EN = 5;

  // status bits
  localparam int ST_SLOT_TO = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_EARLY = 2;
  localparam int ST_TTR_OVR = 3;
  localparam int ST_WDOG_SHORT = 4;
  localparam int ST_ADDR_REJ = 5;
  localparam int ST_GAP = 6;
  localparam int ST_W = 7;

  // limits and reset values, all times in bit times except watchdog in 10 ms units; gap counts rotations
  localparam logic [13:0] SLOT_MIN = 14'h0025;
  localparam logic [13:0] SLOT_MAX = 14'h3FFF;
  localparam logic [13:0] SLOT_DEF = 14'h012C;
  localparam logic [9:0] MINDLY_MIN = 10'h00B;
  localparam logic [9:0] MINDLY_MAX = 10'h3FF;
  localparam logic [9:0] MINDLY_DEF = 10'h00B;
  localparam logic [9:0] MAXDLY_MIN = 10'h025;
  localparam logic [9:0] MAXDLY_MAX = 10'h3FF;
  localparam logic [6:0] QUIET_MAX = 7'h7F;
  localparam logic [7:0] SETUP_MIN = 8'h01;
  localparam logic [7:0] SETUP_MAX = 8'hFF;
  localparam logic [23:0] TTR_MIN = 24'h000100;
  localparam logic [23:0] TTR_MAX = 24'hFFFFFF;
  localparam logic [23:0] TTR_DEF = 24'h00C350;
  localparam logic [6:0] GAP_MIN = 7'h01;
  localparam logic [6:0] GAP_MAX = 7'h64;
  localparam logic [6:0] GAP_DEF = 7'h0A;
  localparam logic [6:0] HSA_MIN = 7'h02;
  localparam logic [6:0] HSA_MAX = 7'h7E;
  localparam logic [6:0] HSA_DEF = 7'h7E;
  localparam logic [6:0] ADDR_MAX = 7'h7D;
  localparam logic [2:0] RETRY_MIN = 3'h1;
  localparam logic [2:0] RETRY_MAX = 3'h7;
  localparam logic [2:0] RETRY_DEF = 3'h1;
  localparam logic [15:0] WDOG_DEF = 16'h0005;

  typedef struct packed {
    logic [9:0] maxdly;
    logic [6:0] quiet;
    logic [7:0] setup;
  } fbt_rate_dflt_t;

  typedef struct packed {
    logic [13:0] slot;
    logic [9:0] mindly;
    logic [6:0] hsa;
    logic [2:0] retry;
  } fbt_cfg_t;

  function automatic int unsigned fbt_rate_hz(input fbt_rate_t r);
    unique case (r)
      FBT_R9K6: return 9_600;
      FBT_R19K2: return 19_200;
      FBT_R45K45: return 45_450;
      FBT_R93K75: return 93_750;
      FBT_R187K5: return 187_500;
      FBT_R500K: return 500_000;
      FBT_R1M5: return 1_500_000;
      FBT_R3M: return 3_000_000;
      FBT_R6M: return 6_000_000;
      default: return 12_000_000;
    endcase
  endfunction : fbt_rate_hz

  // clocks per bit, rounded, never below one
  function automatic logic [11:0] fbt_bit_div(input fbt_rate_t r);
    int unsigned d;
    d = (CLK_HZ + fbt_rate_hz(r) / 2) / fbt_rate_hz(r);
    if (d < 1) d = 1;
    return d[11:0];
  endfunction : fbt_bit_div

  function automatic fbt_rate_dflt_t fbt_dflt(input fbt_rate_t r);
    unique case (r)
      FBT_R500K: return '{10'h064, 7'h00, 8'h01};
      FBT_R1M5: return '{10'h096, 7'h00, 8'h01};
      FBT_R3M: return '{10'h0FA, 7'h03, 8'h04};
      FBT_R6M: return '{10'h1C2, 7'h06, 8'h08};
      FBT_R12M: return '{10'h320, 7'h09, 8'h10};
      default: return '{10'h03C, 7'h00, 8'h01};
    endcase
  endfunction : fbt_dflt
endpackage : fbt_pkg
`default_nettype wire

// ---- fbt_bus_timing_monitor.sv ----
`default_nettype none
module fbt_bus_timing_monitor
  import fbt_pkg::*;
#(
  parameter int unsigned TICK_10MS = TICK_10MS_DEF
) (
  // clock, reset, register port
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // host and link layer
  input wire logic exchange_start_request_i,
  input wire logic tx_start_i,
  input wire logic [6:0] tx_addr_i,
  input wire logic tx_ready_o,
  input wire logic retry_o,
  input wire logic exchange_active_o,
  input wire logic outputs_clear_o,
  input wire logic bit_tick_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // every address up to 2 lies within any legal highest address
  sequence s_accept;
    tx_start_i && tx_ready_o && tx_addr_i <= 7'h02;
  endsequence
  sequence s_reject;
    tx_start_i && tx_ready_o && exchange_start_request_i &&
      tx_addr_i > ADDR_MAX;
  endsequence

  a_tick_one_cycle: assert property (bit_tick_o |=> !bit_tick_o)
    else $error("bit tick wider than one cycle");
  a_accept_busy: assert property (s_accept |-> ##2 !tx_ready_o)
    else $error("legal address not taken");
  a_reject_idle: assert property (s_reject |=> tx_ready_o)
    else $error("illegal address left idle state");
  a_retry_pulse: assert property (retry_o |=> !retry_o)
    else $error("retry wider than one cycle");
  a_clear_halts: assert property (
    outputs_clear_o |-> !exchange_active_o)
    else $error("exchange active while outputs cleared");
  a_active_cause: assert property (
    exchange_active_o |-> $past(exchange_start_request_i))
    else $error("exchange active without request");
  a_restart_low: assert property ($fell(outputs_clear_o) |->
    !$past(exchange_start_request_i) || !$past(exchange_start_request_i, 2)
    || !$past(exchange_start_request_i, 3))
    else $error("clear dropped without request low");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule : fbt_bus_timing_monitor

bind fbt_bus_timing fbt_bus_timing_monitor #(.TICK_10MS(TICK_10MS)) u_mon (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .exchange_start_request_i(exchange_start_request_i),
  .tx_start_i(tx_start_i),
  .tx_addr_i(tx_addr_i),
  .tx_ready_o(tx_ready_o),
  .retry_o(retry_o),
  .exchange_active_o(exchange_active_o),
  .outputs_clear_o(outputs_clear_o),
  .bit_tick_o(bit_tick_o)
);
`default_nettype wire

// ---- fbt_slave_model.sv ----
`default_nettype none
module fbt_slave_model (
  // clock and bit timing
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic bit_tick_i,
  // frames and behaviour
  input wire logic frame_i,
  input wire logic [9:0] delay_i,
  input wire logic mute_i,
  input wire logic [15:0] wdog_i,
  output logic resp_o,
  output logic wdog_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_q;
  logic busy_q;

  // answers delay_i bit times after a frame unless muted
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b0;
      resp_o <= 1'b0;
      cnt_q <= 16'h0;
    end else begin
      resp_o <= 1'b0;
      if (frame_i) begin
        busy_q <= !mute_i;
        cnt_q <= 16'h0;
      end else if (bit_tick_i) begin
        cnt_q <= cnt_q + 16'h1;
        if (busy_q && cnt_q == {6'h0, delay_i}) begin
          resp_o <= 1'b1;
          busy_q <= 1'b0;
        end
      end
    end
  end
  // zero watchdog time means watchdog off
  assign wdog_err_o = wdog_i != 16'h0 && cnt_q >= wdog_i;
endmodule : fbt_slave_model
`default_nettype wire

// ---- fbt_bus_timing_tb_top.sv ----
`default_nettype none
module fbt_bus_timing_tb_top
  import fbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, req, tx_start, rx_resp;
  logic rot_done, tx_ready, retry, active, clr, gap, tick, irq, mute;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [6:0] tx_addr;
  logic [9:0] dly;
  int n_errors, cmp_count;
  int hz[10] = '{9600, 19200, 45450, 93750, 187500, 500000, 1500000,
                 3000000, 6000000, 12000000};
  localparam logic [39:0] RV [10] = '{{OFS_SLOT, 32'h12C},
    {OFS_MINDLY, 32'hB}, {OFS_MAXDLY, 32'h96}, {OFS_QUIET, 32'h0},
    {OFS_SETUP, 32'h1}, {OFS_TTR, 32'hC350}, {OFS_GAP, 32'hA},
    {OFS_HSA, 32'h7E}, {OFS_RETRY, 32'h1}, {OFS_WDOG, 32'h5}};
  localparam logic [71:0] CL [13] = '{{OFS_SLOT, 32'h0, 32'h25},
    {OFS_SLOT, 32'hFFFFF, 32'h3FFF}, {OFS_MINDLY, 32'h0, 32'hB},
    {OFS_MINDLY, 32'h7FF, 32'h3FF}, {OFS_MAXDLY, 32'h0, 32'h25},
    {OFS_QUIET, 32'hFF, 32'h7F}, {OFS_SETUP, 32'h0, 32'h1},
    {OFS_TTR, 32'h0, 32'h100}, {OFS_TTR, 32'h1FFFFFF, 32'hFFFFFF},
    {OFS_GAP, 32'h0, 32'h1}, {OFS_GAP, 32'hFF, 32'h64},
    {OFS_HSA, 32'h1, 32'h2}, {OFS_RETRY, 32'h0, 32'h1}};

  fbt_bus_timing #(.TICK_10MS(20)) DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .exchange_start_request_i(req), .tx_start_i(tx_start),
    .tx_addr_i(tx_addr), .rx_resp_i(rx_resp), .rotation_done_i(rot_done),
    .tx_ready_o(tx_ready), .retry_o(retry), .exchange_active_o(active),
    .outputs_clear_o(clr), .gap_update_o(gap), .bit_tick_o(tick),
    .irq_o(irq));
  fbt_slave_model u_slave (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bit_tick_i(tick),
    .frame_i(tx_start | retry), .delay_i(dly), .mute_i(mute),
    .wdog_i(16'h0), .resp_o(rx_resp), .wdog_err_o());

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    chk(reg_rdata_o, e);
  endtask : rchk

  task automatic wait_ready();
    for (int i = 0; i < 5000 && tx_ready !== 1'b1; i++) begin
      @(posedge core_clk_i);
    end
  endtask : wait_ready

  task automatic xfer(input logic [6:0] a);
    wait_ready();
    tx_addr <= a;
    tx_start <= 1'b1;
    @(posedge core_clk_i);
    tx_start <= 1'b0;
  endtask : xfer

  // clocks between two bit ticks
  task automatic tick_gap(output int n);
    n = 1;
    for (int i = 0; i < 5000 && tick !== 1'b1; i++) @(posedge core_clk_i);
    @(posedge core_clk_i);
    while (tick !== 1'b1 && n < 5000) begin
      n++;
      @(posedge core_clk_i);
    end
  endtask : tick_gap

  function automatic logic [24:0] rdef(input int r);
    case (r)
      5: return {10'h064, 7'h00, 8'h01};
      6: return {10'h096, 7'h00, 8'h01};
      7: return {10'h0FA, 7'h03, 8'h04};
      8: return {10'h1C2, 7'h06, 8'h08};
      9: return {10'h320, 7'h09, 8'h10};
      default: return {10'h03C, 7'h00, 8'h01};
    endcase
  endfunction : rdef

  initial begin
    #3_000_000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    int v, n, k;
    logic [24:0] e;
    {reset_n_i, reg_wr_i, reg_rd_i, req, tx_start, rot_done, mute} = 7'h0;
    reg_addr_i = 8'h0;
    reg_wdata_i = 32'h0;
    tx_addr = 7'h0;
    dly = 10'h14;
    void'($urandom(32'hEA099D1F));
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    foreach (RV[i]) rchk(RV[i][39:32], RV[i][31:0]);
    rchk(8'h38, 32'h0);
    for (int r = 0; r < 11; r++) begin
      k = r < 10 ? r : 9;
      e = rdef(k);
      wr(OFS_CTRL, 32'(r));
      rchk(OFS_MAXDLY, 32'(e[24:15]));
      rchk(OFS_QUIET, 32'(e[14:8]));
      rchk(OFS_SETUP, 32'(e[7:0]));
      tick_gap(n);
      chk(n, (20_000_000 + hz[k] / 2) / hz[k]);
    end
    foreach (CL[i]) begin
      wr(CL[i][71:64], CL[i][63:32]);
      rchk(CL[i][71:64], CL[i][31:0]);
    end
    v = 37 + $urandom % 16347;
    wr(OFS_SLOT, v);
    rchk(OFS_SLOT, v);
    wr(OFS_CTRL, 32'h19);
    wr(OFS_SLOT, 32'h25);
    wr(OFS_MINDLY, 32'hB);
    wr(OFS_HSA, 32'h7E);
    wr(OFS_MASK, 32'h7F);
    req <= 1'b1;
    dly <= 10'(11 + $urandom % 15);
    xfer(7'h7D);
    wait_ready();
    rchk(OFS_STATUS, 32'h0);
    dly <= 10'h2;
    xfer(7'h02);
    wait_ready();
    rchk(OFS_STATUS, 32'h4);
    chk(irq, 1'b1);
    wr(OFS_MASK, 32'h0);
    rchk(OFS_STATUS, 32'h4);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h7F);
    wr(OFS_STATUS, 32'h4);
    rchk(OFS_STATUS, 32'h0);
    xfer(7'(8'h7E + $urandom % 2));
    rchk(OFS_STATUS, 32'h20);
    wr(OFS_HSA, 32'hA);
    wr(OFS_STATUS, 32'h20);
    rchk(OFS_STATUS, 32'h0);
    xfer(7'hB);
    rchk(OFS_STATUS, 32'h20);
    wr(OFS_HSA, 32'h7E);
    wr(OFS_STATUS, 32'h20);
    v = 1 + $urandom % 3;
    wr(OFS_RETRY, v);
    mute <= 1'b1;
    xfer(7'h09);
    k = 0;
    for (n = 0; n < 3000 && clr !== 1'b1; n++) begin
      @(posedge core_clk_i);
      if (retry === 1'b1) k++;
    end
    chk(k, v);
    chk(clr, 1'b1);
    rchk(OFS_STATUS, 32'h3);
    chk(active, 1'b0);
    mute <= 1'b0;
    req <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    req <= 1'b1;
    for (n = 0; n < 20 && clr !== 1'b0; n++) @(posedge core_clk_i);
    wait_ready();
    chk(clr, 1'b0);
    chk(active, 1'b1);
    wr(OFS_STATUS, 32'h7F);
    wr(OFS_GAP, 32'h3);
    k = 0;
    repeat (6) begin
      rot_done <= 1'b1;
      @(posedge core_clk_i);
      rot_done <= 1'b0;
      repeat (4) begin
        @(posedge core_clk_i);
        if (gap === 1'b1) k++;
      end
    end
    chk(k, 2);
    wr(OFS_CTRL, 32'h39);
    wr(OFS_STATUS, 32'h7F);
    rot_done <= 1'b1;
    @(posedge core_clk_i);
    rot_done <= 1'b0;
    repeat (140) @(posedge core_clk_i);
    rot_done <= 1'b1;
    @(posedge core_clk_i);
    rot_done <= 1'b0;
    @(posedge core_clk_i);
    rchk(OFS_STATUS, 32'h10);
    conclude();
  end
endmodule : fbt_bus_timing_tb_top
`default_nettype wire
